// ==== core/pss_defs.vh ====
// Constants for the scan cycle sequencer: register offsets, fields, resets, timing.
// Assumes a 250 MHz system clock and a one-cycle-latency register port.
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

`define PSS_CLK_MHZ        250
`define PSS_MS_CYCLES      (`PSS_CLK_MHZ * 1000)
`define PSS_WIN_LIMIT_MS   6
`define PSS_SYS_LIMIT_MS   400
`define PSS_WDOG_MS        500
`define PSS_CSW_MIN_MS     5
`define PSS_CSW_MAX_MS     500
`define PSS_CSW_RESET_MS   9'h064
`define PSS_CSUM_MAX_WORDS 32

`define PSS_SVC_CONST      8'h01
`define PSS_SVC_STOP       8'h0D

// Register offsets
`define PSS_REG_CTRL       4'h0
`define PSS_REG_CSW        4'h1
`define PSS_REG_CSUM_CFG   4'h2
`define PSS_REG_STATUS     4'h3
`define PSS_REG_FAULT      4'h4
`define PSS_REG_SWEEP_MS   4'h5
`define PSS_REG_SVC        4'h6
`define PSS_REG_FAULT_CLR  4'h7

// CTRL fields
`define PSS_CTRL_RUN       0
`define PSS_CTRL_IO_STOP   1
`define PSS_CTRL_CONST     2
`define PSS_CTRL_PGM_RTC   3
`define PSS_CTRL_SYS_LIM   4
`define PSS_CTRL_RESET     8'h00

// FAULT fields
`define PSS_FLT_CSUM       0
`define PSS_FLT_CFG        1
`define PSS_FLT_WDOG       2
`define PSS_FLT_OVSWP      3
`define PSS_FLT_SVCSTOP    4

`endif

// ==== core/pss_ms_tick.v ====
// Millisecond tick divider.
// Assumes a single free-running system clock.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"
module pss_ms_tick #(
  parameter integer CYCLES = `PSS_MS_CYCLES
) (
  // Clock and reset
  input  wire clk_in,
  input  wire nrst_in,
  // Tick
  output reg  tick_out
);
  reg [31:0] cnt_q;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/pss_sync3.v ====
// Three-stage synchroniser; a change counts once stages two and three agree.
// Assumes asynchronous inputs from pins.
`timescale 1ns/1ps
`default_nettype none
module pss_sync3 #(
  parameter integer W = 1
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         nrst_in,
  // Data
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q_out <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== core/pss_sequencer.v ====
// Scan cycle sequencer: phase machine, window timers, watchdog, constant sweep, checks.
// Assumes phase workers outside answer with same-clock done strobes; pin inputs are async.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"
module pss_sequencer #(
  parameter integer MS_CYCLES = `PSS_MS_CYCLES,
  parameter integer N_OUT     = 8,
  parameter integer N_OPT     = 4,
  parameter integer N_MOD     = 8
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        nrst_in,
  // Register port
  input  wire [3:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // Pins from outside
  input  wire        programmer_attached_in,
  input  wire        producer_expired_in,
  // Phase workers
  input  wire        input_done_in,
  input  wire        solve_done_in,
  input  wire        out_ack_in,
  input  wire        pgm_req_in,
  input  wire        pgm_done_in,
  input  wire [N_OPT-1:0] opt_req_in,
  input  wire        opt_done_in,
  input  wire        cfg_match_in,
  input  wire        cfg_present_in,
  input  wire        cfg_expected_in,
  input  wire [15:0] prog_word_in,
  input  wire [15:0] ref_csum_in,
  // Service call from the program
  input  wire        program_service_call_in,
  input  wire [7:0]  svc_code_in,
  input  wire        svc_enable_in,
  input  wire [8:0]  svc_len_in,
  // Phase controls
  output reg  [6:0]  phase_out,
  output reg         input_go_out,
  output reg         solve_go_out,
  output reg         out_wr_out,
  output reg  [7:0]  out_addr_out,
  output reg         exch_copy_out,
  output reg         pgm_go_out,
  output reg         pgm_suspend_out,
  output reg         opt_poll_out,
  output reg  [7:0]  opt_sel_out,
  output reg         sys_suspend_out,
  output reg  [7:0]  cfg_slot_out,
  output reg  [5:0]  csum_addr_out,
  output reg         io_default_out,
  output reg         health_ok_out,
  output reg         oversweep_flag_out,
  output reg         svc_const_en_out,
  output reg  [8:0]  svc_len_out,
  output reg         powerup_out
);
  localparam [6:0] S_HK  = 7'h01, S_IN  = 7'h02, S_SOL = 7'h04, S_OUT = 7'h08;
  localparam [6:0] S_PGM = 7'h10, S_SYS = 7'h20, S_DIA = 7'h40;

  wire tick;
  wire pgm_att;
  wire prod_exp;
  pss_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .tick_out (tick)
  );
  pss_sync3 #(.W(2)) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    ({programmer_attached_in, producer_expired_in}),
    .q_out   ({pgm_att, prod_exp})
  );

  reg [6:0]  st_q;
  reg [7:0]  ctrl_q;
  reg [8:0]  csw_len_q;
  reg [5:0]  csum_words_q;
  reg [4:0]  fault_q;
  reg [9:0]  sweep_ms_q;
  reg [9:0]  last_sweep_q;
  reg [9:0]  win_ms_q;
  reg [15:0] csum_q;
  reg        ovs_pend_q;
  reg        ovs_log_q;
  reg        stop_req_q;
  reg        sub_q;
  reg        pgm_busy_q;
  reg        sys_busy_q;
  reg [7:0]  rr_q;
  reg        csum_fail_q;

  wire run      = ctrl_q[`PSS_CTRL_RUN];
  wire io_stop  = ctrl_q[`PSS_CTRL_IO_STOP];
  wire const_en = ctrl_q[`PSS_CTRL_CONST];
  wire io_on    = run | io_stop;
  wire wdog_exp = !const_en && tick && (sweep_ms_q == `PSS_WDOG_MS - 1);
  wire win6     = tick && (win_ms_q == `PSS_WIN_LIMIT_MS - 1);
  wire win400   = tick && (win_ms_q == `PSS_SYS_LIMIT_MS - 1);
  wire sys_lim  = ctrl_q[`PSS_CTRL_SYS_LIM];
  wire csw_ok   = (svc_len_in >= `PSS_CSW_MIN_MS) && (svc_len_in <= `PSS_CSW_MAX_MS);

  // Round-robin pick: first requester at or after the rotating pointer
  reg [7:0] pick;
  reg       pick_v;
  integer   k;
  integer   idx;
  always @* begin
    pick   = 8'h00;
    pick_v = 1'b0;
    for (k = N_OPT - 1; k >= 0; k = k - 1) begin
      idx = (rr_q + k) % N_OPT;
      if (opt_req_in[idx]) begin
        pick   = idx[7:0];
        pick_v = 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= S_HK; ctrl_q <= `PSS_CTRL_RESET; csw_len_q <= `PSS_CSW_RESET_MS;
      csum_words_q <= 6'h00; fault_q <= 5'h00; sweep_ms_q <= 10'h000;
      last_sweep_q <= 10'h000; win_ms_q <= 10'h000; csum_q <= 16'h0000;
      ovs_pend_q <= 1'b0; ovs_log_q <= 1'b0; stop_req_q <= 1'b0; sub_q <= 1'b0;
      pgm_busy_q <= 1'b0; sys_busy_q <= 1'b0; rr_q <= 8'h00; csum_fail_q <= 1'b0;
      reg_rdata_out <= 32'h0; phase_out <= S_HK; input_go_out <= 1'b0;
      solve_go_out <= 1'b0; out_wr_out <= 1'b0; out_addr_out <= 8'h00;
      exch_copy_out <= 1'b0; pgm_go_out <= 1'b0; pgm_suspend_out <= 1'b0;
      opt_poll_out <= 1'b0; opt_sel_out <= 8'h00; sys_suspend_out <= 1'b0;
      cfg_slot_out <= 8'h00; csum_addr_out <= 6'h00; io_default_out <= 1'b1;
      health_ok_out <= 1'b1; oversweep_flag_out <= 1'b0; svc_const_en_out <= 1'b0;
      svc_len_out <= `PSS_CSW_RESET_MS; powerup_out <= 1'b1;
    end else begin
      input_go_out <= 1'b0; solve_go_out <= 1'b0; out_wr_out <= 1'b0;
      exch_copy_out <= 1'b0; pgm_go_out <= 1'b0; opt_poll_out <= 1'b0;
      pgm_suspend_out <= 1'b0; sys_suspend_out <= 1'b0; powerup_out <= 1'b0;
      if (tick && sweep_ms_q != 10'h3FF)
        sweep_ms_q <= sweep_ms_q + 10'h001;
      if (tick && win_ms_q != 10'h3FF)
        win_ms_q <= win_ms_q + 10'h001;
      if (!const_en)
        oversweep_flag_out <= 1'b0;
      // Register port
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `PSS_REG_CTRL:     reg_rdata_out <= {24'h0, ctrl_q};
          `PSS_REG_CSW:      reg_rdata_out <= {23'h0, csw_len_q};
          `PSS_REG_CSUM_CFG: reg_rdata_out <= {26'h0, csum_words_q};
          `PSS_REG_STATUS:   reg_rdata_out <= {22'h0, oversweep_flag_out, csum_fail_q,
                                               health_ok_out, st_q};
          `PSS_REG_FAULT:    reg_rdata_out <= {27'h0, fault_q};
          `PSS_REG_SWEEP_MS: reg_rdata_out <= {22'h0, last_sweep_q};
          `PSS_REG_SVC:      reg_rdata_out <= {22'h0, svc_const_en_out, svc_len_out};
          default:           reg_rdata_out <= 32'h0;
        endcase
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `PSS_REG_CTRL: ctrl_q <= reg_wdata_in[7:0];
          `PSS_REG_CSW:
            if (reg_wdata_in[8:0] >= `PSS_CSW_MIN_MS && reg_wdata_in[8:0] <= `PSS_CSW_MAX_MS)
              csw_len_q <= reg_wdata_in[8:0];
          `PSS_REG_CSUM_CFG:
            if (reg_wdata_in[5:0] <= `PSS_CSUM_MAX_WORDS)
              csum_words_q <= reg_wdata_in[5:0];
          `PSS_REG_FAULT_CLR: begin
            fault_q     <= fault_q & ~reg_wdata_in[4:0];
            csum_fail_q <= csum_fail_q & ~reg_wdata_in[`PSS_FLT_CSUM];
          end
          default: ;
        endcase
      end
      // Service calls from the program
      if (program_service_call_in && svc_code_in == `PSS_SVC_CONST) begin
        if (svc_enable_in) begin
          ctrl_q[`PSS_CTRL_CONST] <= 1'b1;
          if (csw_ok)
            csw_len_q <= svc_len_in;
        end else begin
          ctrl_q[`PSS_CTRL_CONST] <= 1'b0;
        end
      end
      svc_const_en_out <= const_en;
      svc_len_out      <= csw_len_q;
      if (program_service_call_in && svc_code_in == `PSS_SVC_STOP)
        stop_req_q <= 1'b1;
      // Sweep phases
      case (st_q)
        S_HK: begin
          if (const_en && sweep_ms_q < {1'b0, csw_len_q} && !sub_q) begin
            st_q <= S_HK;
          end else begin
            if (const_en && sweep_ms_q > {1'b0, csw_len_q})
              oversweep_flag_out <= 1'b1;
            else if (!const_en || !ovs_pend_q)
              oversweep_flag_out <= 1'b0;
            if (ovs_log_q) begin
              oversweep_flag_out <= 1'b1;
              ovs_log_q <= 1'b0;
            end
            if (ovs_pend_q) begin
              fault_q[`PSS_FLT_OVSWP] <= 1'b1;
              ovs_pend_q <= 1'b0;
              ovs_log_q  <= 1'b1;
            end
            last_sweep_q <= sweep_ms_q;
            sweep_ms_q   <= 10'h000;
            io_default_out <= !io_on;
            input_go_out <= io_on;
            st_q <= io_on ? S_IN : (pgm_att ? S_PGM : S_SYS);
            phase_out <= io_on ? S_IN : (pgm_att ? S_PGM : S_SYS);
            win_ms_q <= 10'h000;
          end
        end
        S_IN:
          if (input_done_in) begin
            solve_go_out <= run;
            st_q <= run ? S_SOL : S_OUT;
            phase_out <= run ? S_SOL : S_OUT;
            out_addr_out <= 8'h00;
          end
        S_SOL:
          if (solve_done_in || !run) begin
            st_q <= S_OUT;
            phase_out <= S_OUT;
            out_addr_out <= 8'h00;
            sub_q <= 1'b0;
          end
        S_OUT: begin
          if (!io_on || (sub_q && out_ack_in && out_addr_out == N_OUT - 1)) begin
            exch_copy_out <= io_on && prod_exp;
            st_q <= pgm_att ? S_PGM : S_SYS;
            phase_out <= pgm_att ? S_PGM : S_SYS;
            win_ms_q <= 10'h000;
            sub_q <= 1'b0;
          end else if (!sub_q) begin
            out_wr_out <= 1'b1;
            sub_q <= 1'b1;
          end else if (out_ack_in) begin
            out_addr_out <= out_addr_out + 8'h01;
            sub_q <= 1'b0;
          end
        end
        S_PGM: begin
          if (!sub_q && (pgm_req_in || pgm_busy_q)) begin
            pgm_go_out <= 1'b1;
            sub_q <= 1'b1;
          end else if (pgm_done_in || !(pgm_req_in || pgm_busy_q) ||
                       (ctrl_q[`PSS_CTRL_PGM_RTC] ? win400 : win6)) begin
            pgm_busy_q <= sub_q && !pgm_done_in;
            pgm_suspend_out <= sub_q && !pgm_done_in;
            st_q <= S_SYS;
            phase_out <= S_SYS;
            win_ms_q <= 10'h000;
            sub_q <= 1'b0;
          end
        end
        S_SYS: begin
          if ((sys_lim ? win6 : win400) || (!sub_q && !pick_v && !sys_busy_q)) begin
            sys_busy_q <= sub_q;
            sys_suspend_out <= sub_q;
            st_q <= S_DIA;
            phase_out <= S_DIA;
            csum_q <= 16'h0000;
            csum_addr_out <= 6'h00;
            sub_q <= 1'b0;
          end else if (!sub_q) begin
            opt_poll_out <= 1'b1;
            sub_q <= 1'b1;
            if (!sys_busy_q) begin
              opt_sel_out <= pick;
              rr_q <= (pick == N_OPT - 1) ? 8'h00 : pick + 8'h01;
            end
          end else if (opt_done_in) begin
            sub_q <= 1'b0;
            sys_busy_q <= 1'b0;
          end
        end
        S_DIA: begin
          if (csum_addr_out < csum_words_q) begin
            csum_q <= csum_q + prog_word_in;
            csum_addr_out <= csum_addr_out + 6'h01;
          end else begin
            if (csum_words_q != 6'h00 && csum_q != ref_csum_in) begin
              csum_fail_q <= 1'b1;
              fault_q[`PSS_FLT_CSUM] <= 1'b1;
              ctrl_q[`PSS_CTRL_RUN] <= 1'b0;
            end
            if ((cfg_present_in != cfg_expected_in) || (cfg_present_in && !cfg_match_in))
              fault_q[`PSS_FLT_CFG] <= 1'b1;
            cfg_slot_out <= (cfg_slot_out == N_MOD - 1) ? 8'h00 : cfg_slot_out + 8'h01;
            if (stop_req_q) begin
              ctrl_q[`PSS_CTRL_RUN] <= 1'b0;
              fault_q[`PSS_FLT_SVCSTOP] <= 1'b1;
              stop_req_q <= 1'b0;
            end
            if (const_en && sweep_ms_q > {1'b0, csw_len_q})
              ovs_pend_q <= 1'b1;
            st_q <= S_HK;
            phase_out <= S_HK;
          end
        end
        default: st_q <= S_HK;
      endcase
      // Watchdog overrides everything: restart as at power-up, stopped
      if (wdog_exp) begin
        health_ok_out <= 1'b0;
        powerup_out <= 1'b1;
        fault_q[`PSS_FLT_WDOG] <= 1'b1;
        ctrl_q[`PSS_CTRL_RUN] <= 1'b0;
        st_q <= S_HK;
        phase_out <= S_HK;
        sweep_ms_q <= 10'h000;
        sub_q <= 1'b0;
        pgm_busy_q <= 1'b0;
        sys_busy_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/pss_sequencer_properties.sv ====
// Port-level checker for the scan sequencer, bound into every instance.
// Assumes one clock and a millisecond of MS_CYCLES clock cycles.
`timescale 1ns/1ps
`default_nettype none
module pss_seq_props #(
  parameter integer MS_CYCLES = 10,
  parameter integer N_OUT     = 8
) (
  // Clock, reset and pins
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       programmer_attached_in,
  // Observed outputs
  input wire logic [6:0] phase_out,
  input wire logic       out_wr_out,
  input wire logic [7:0] out_addr_out,
  input wire logic       pgm_go_out,
  input wire logic       health_ok_out,
  input wire logic       powerup_out,
  input wire logic       oversweep_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0]  wcnt_q;
  logic        pgo_q;
  logic [31:0] tpgm_q;
  logic [31:0] tsys_q;
  logic [31:0] swp_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wcnt_q <= 8'h00;
      pgo_q  <= 1'b0;
      tpgm_q <= 32'h0;
      tsys_q <= 32'h0;
      swp_q  <= 32'h0;
    end else begin
      wcnt_q <= !phase_out[3] ? 8'h00 : wcnt_q + {7'h00, out_wr_out};
      pgo_q  <= phase_out[0] ? 1'b0 : (pgo_q | pgm_go_out);
      tpgm_q <= phase_out[4] ? tpgm_q + 32'h1 : 32'h0;
      tsys_q <= phase_out[5] ? tsys_q + 32'h1 : 32'h0;
      swp_q  <= phase_out[0] ? 32'h0 : swp_q + 32'h1;
    end
  end
  sequence s_solve_end; $fell(phase_out[2]); endsequence
  sequence s_pgm_start; $rose(phase_out[4]); endsequence
  property p_onehot; $onehot(phase_out); endproperty
  property p_out_next; s_solve_end |-> phase_out[3]; endproperty
  property p_out_order; out_wr_out |-> out_addr_out == wcnt_q; endproperty
  property p_out_all; $fell(phase_out[3]) |-> wcnt_q == 8'(N_OUT); endproperty
  // Pin passes a synchroniser, so an older sample also counts
  property p_pgm_att;
    s_pgm_start |-> programmer_attached_in || $past(programmer_attached_in, 6);
  endproperty
  property p_pgm_once; pgm_go_out |-> !pgo_q; endproperty
  property p_pgm_cap; phase_out[4] |-> tpgm_q < 7 * MS_CYCLES + 4; endproperty
  property p_sys_cap; phase_out[5] |-> tsys_q < 401 * MS_CYCLES + 4; endproperty
  property p_wdog_late; $fell(health_ok_out) |-> swp_q >= 498 * MS_CYCLES; endproperty
  property p_wdog_boot; $rose(powerup_out) |-> ##[0:3] !health_ok_out; endproperty
  property p_ovs_hk; $rose(oversweep_flag_out) |-> phase_out[0] || $past(phase_out[0]); endproperty
  a_onehot: assert property (p_onehot) else $error("phase not one-hot");
  a_out_next: assert property (p_out_next) else $error("output phase not after solve");
  a_out_order: assert property (p_out_order) else $error("output address out of order");
  a_out_all: assert property (p_out_all) else $error("output phase left early");
  a_pgm_att: assert property (p_pgm_att) else $error("programmer phase without device");
  a_pgm_once: assert property (p_pgm_once) else $error("second programmer request");
  a_pgm_cap: assert property (p_pgm_cap) else $error("programmer window too long");
  a_sys_cap: assert property (p_sys_cap) else $error("system window too long");
  a_wdog_late: assert property (p_wdog_late) else $error("watchdog fired early");
  a_wdog_boot: assert property (p_wdog_boot) else $error("powerup without health loss");
  a_ovs_hk: assert property (p_ovs_hk) else $error("oversweep flag set off housekeeping");
endmodule
bind pss_sequencer pss_seq_props #(.MS_CYCLES(MS_CYCLES), .N_OUT(N_OUT)) u_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .programmer_attached_in(programmer_attached_in),
  .phase_out(phase_out), .out_wr_out(out_wr_out), .out_addr_out(out_addr_out),
  .pgm_go_out(pgm_go_out), .health_ok_out(health_ok_out), .powerup_out(powerup_out),
  .oversweep_flag_out(oversweep_flag_out));
`default_nettype wire

// ==== sim/pss_far_model.sv ====
// Far-side model: I/O workers, option modules and a programming device.
// Assumes one-cycle go strobes from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pss_far_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Strobes from the sequencer
  input  wire logic        input_go_in,
  input  wire logic        solve_go_in,
  input  wire logic        out_wr_in,
  input  wire logic        pgm_go_in,
  input  wire logic        pgm_suspend_in,
  input  wire logic        opt_poll_in,
  // Bench controls
  input  wire logic [15:0] slow_in,
  input  wire logic [15:0] pgm_len_in,
  input  wire logic        pgm_load_in,
  input  wire logic [3:0]  opt_mask_in,
  input  wire logic        cfg_bad_in,
  // Answers
  output logic             input_done_out,
  output logic             solve_done_out,
  output logic             out_ack_out,
  output logic             pgm_req_out,
  output logic             pgm_done_out,
  output logic [3:0]       opt_req_out,
  output logic             opt_done_out,
  output logic             cfg_match_out,
  output logic [15:0]      prog_word_out
);
  logic [15:0] ki_q, rem_q;
  logic [1:0]  ks_q, ko_q, kp_q;
  logic        busy_q;
  // A request stays raised across suspended windows until fully served
  assign pgm_req_out   = (rem_q != 16'h0000);
  assign opt_req_out   = opt_mask_in;
  assign cfg_match_out = !cfg_bad_in;
  assign prog_word_out = 16'h0000;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {ki_q, rem_q, ks_q, ko_q, kp_q, busy_q} <= '0;
      {input_done_out, solve_done_out, out_ack_out, pgm_done_out, opt_done_out} <= '0;
    end else begin
      input_done_out <= (ki_q == 16'h0001);
      solve_done_out <= (ks_q == 2'h1);
      out_ack_out    <= (ko_q == 2'h1);
      opt_done_out   <= (kp_q == 2'h1);
      pgm_done_out   <= busy_q && (rem_q == 16'h0001);
      ki_q <= input_go_in ? slow_in : ki_q - {15'h0, ki_q != 16'h0};
      ks_q <= solve_go_in ? 2'h3 : ks_q - {1'b0, ks_q != 2'h0};
      ko_q <= out_wr_in ? 2'h2 : ko_q - {1'b0, ko_q != 2'h0};
      kp_q <= opt_poll_in ? 2'h2 : kp_q - {1'b0, kp_q != 2'h0};
      if (pgm_load_in) rem_q <= pgm_len_in;
      else if (busy_q && rem_q != 16'h0) rem_q <= rem_q - 16'h1;
      if (pgm_go_in) busy_q <= 1'b1;
      else if (pgm_suspend_in || rem_q == 16'h1) busy_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_pss_sequencer.sv ====
// Bench for the scan sequencer: register port, phase workers and service calls.
// Assumes the far-side model answers every strobe; a millisecond is 10 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_pss_sequencer;
  localparam integer MS = 10;
  logic        clk_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, att = 1'b0;
  logic        pexp = 1'b0, psc = 1'b0, sen = 1'b0, pload = 1'b0, cbad = 1'b0, hk_p = 1'b0;
  logic [3:0]  ra = 4'h0, omask = 4'h0, oreq, seen;
  logic [31:0] wd = 32'h0, rdata, v;
  logic [7:0]  scode = 8'h00, oa, osel;
  logic [8:0]  slen = 9'h000, clen;
  logic [15:0] refc = 16'h0000, slow = 16'h0002, plen = 16'h0000, pw;
  logic [6:0]  phase;
  logic        idn, sdn, ack, preq, pdn, odn, cm, ig, sg, ow, ec, pg, ps, op, iod, hok, ovs, cen, pup;
  int          n_errors = 0, cmp_count = 0, c_sol, c_out, c_ex, c_pg, c_su, c_pd, c_hk;
  pss_sequencer #(.MS_CYCLES(MS), .N_OUT(4), .N_OPT(4), .N_MOD(8)) DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .programmer_attached_in(att), .producer_expired_in(pexp), .input_done_in(idn),
    .solve_done_in(sdn), .out_ack_in(ack), .pgm_req_in(preq), .pgm_done_in(pdn),
    .opt_req_in(oreq), .opt_done_in(odn), .cfg_match_in(cm), .cfg_present_in(1'b1),
    .cfg_expected_in(1'b1), .prog_word_in(pw), .ref_csum_in(refc),
    .program_service_call_in(psc), .svc_code_in(scode), .svc_enable_in(sen),
    .svc_len_in(slen), .phase_out(phase), .input_go_out(ig), .solve_go_out(sg),
    .out_wr_out(ow), .out_addr_out(oa), .exch_copy_out(ec), .pgm_go_out(pg),
    .pgm_suspend_out(ps), .opt_poll_out(op), .opt_sel_out(osel), .sys_suspend_out(),
    .cfg_slot_out(), .csum_addr_out(), .io_default_out(iod), .health_ok_out(hok),
    .oversweep_flag_out(ovs), .svc_const_en_out(cen), .svc_len_out(clen), .powerup_out(pup));
  pss_far_model u_far (.clk_in(clk_in), .nrst_in(nrst_in), .input_go_in(ig),
    .solve_go_in(sg), .out_wr_in(ow), .pgm_go_in(pg), .pgm_suspend_in(ps),
    .opt_poll_in(op), .slow_in(slow), .pgm_len_in(plen), .pgm_load_in(pload),
    .opt_mask_in(omask), .cfg_bad_in(cbad), .input_done_out(idn), .solve_done_out(sdn),
    .out_ack_out(ack), .pgm_req_out(preq), .pgm_done_out(pdn), .opt_req_out(oreq),
    .opt_done_out(odn), .cfg_match_out(cm), .prog_word_out(pw));
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    c_sol += int'(sg);
    c_out += int'(ow);
    c_ex += int'(ec);
    c_pg += int'(pg);
    c_su += int'(ps);
    c_pd += int'(pdn);
    c_hk += int'(phase[0] & ~hk_p);
    hk_p = phase[0];
    if (op) seen[osel[1:0]] = 1'b1;
  end
  task automatic span(input int n);
    @(negedge clk_in);
    {c_sol, c_out, c_ex, c_pg, c_su, c_pd, c_hk} = '0;
    seen = 4'h0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m, e);
    @(posedge clk_in);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    `CHK(nm, e, rdata & m)
  endtask
  // Calls are made while the program is being solved, as a program would
  task automatic svc(input logic [7:0] c, input logic en, input logic [8:0] l);
    int k;
    for (k = 0; k < 3000 && phase !== 7'h04; k++) @(posedge clk_in);
    psc <= 1'b1;
    scode <= c;
    sen <= en;
    slen <= l;
    @(posedge clk_in);
    psc <= 1'b0;
  endtask
  task automatic load_pgm(input logic [15:0] l);
    @(posedge clk_in);
    plen <= l;
    pload <= 1'b1;
    @(posedge clk_in);
    pload <= 1'b0;
  endtask
  task automatic t_regs();
    int wv[4] = '{4, 5, 501, 500};
    int ev[4] = '{`PSS_CSW_RESET_MS, 5, 5, 500};
    rchk("ctrl", `PSS_REG_CTRL, 32'hFF, 32'h0);
    rchk("fault", `PSS_REG_FAULT, 32'h1F, 32'h0);
    rchk("unmapped", 4'h8, 32'hFFFFFFFF, 32'h0);
    rchk("csw", `PSS_REG_CSW, 32'h1FF, `PSS_CSW_RESET_MS);
    for (int i = 0; i < 4; i++) begin
      wreg(`PSS_REG_CSW, wv[i]);
      rchk("csw", `PSS_REG_CSW, 32'h1FF, ev[i]);
    end
    wreg(`PSS_REG_CSUM_CFG, 32);
    wreg(`PSS_REG_CSUM_CFG, 33);
    rchk("csum_words", `PSS_REG_CSUM_CFG, 32'h3F, 32);
    wreg(`PSS_REG_CSUM_CFG, 0);
  endtask
  task automatic t_stop();
    span(300);
    `CHK("solve", 0, c_sol)
    `CHK("outputs", 0, c_out)
    wreg(`PSS_REG_CTRL, 1 << `PSS_CTRL_IO_STOP);
    span(300);
    `CHK("solve", 0, c_sol)
    `CHK("outputs", 1'b1, c_out > 0)
  endtask
  task automatic t_run();
    wreg(`PSS_REG_CTRL, 1 << `PSS_CTRL_RUN);
    span(300);
    `CHK("outputs", 1'b1, c_out > 0)
    `CHK("exchange", 0, c_ex)
    @(posedge clk_in) pexp <= 1'b1;
    span(300);
    `CHK("exchange", 1'b1, c_ex > 0)
  endtask
  task automatic t_pgm();
    load_pgm(16'd10);
    span(300);
    `CHK("pgm_go", 0, c_pg)
    @(posedge clk_in) att <= 1'b1;
    span(300);
    `CHK("pgm_done", 1'b1, c_pd > 0)
    load_pgm(16'd200);
    span(2000);
    `CHK("pgm_suspend", 1'b1, c_su > 0)
    `CHK("pgm_done", 1, c_pd)
  endtask
  task automatic t_sys();
    wreg(`PSS_REG_CTRL, (1 << `PSS_CTRL_RUN) | (1 << `PSS_CTRL_SYS_LIM));
    @(posedge clk_in) omask <= 4'hF;
    span(800);
    `CHK("polled", 4'hF, seen)
  endtask
  task automatic t_csw();
    @(posedge clk_in) omask <= 4'h0;
    svc(`PSS_SVC_CONST, 1'b1, 9'd5);
    span(500);
    `CHK("const_en", 1'b1, cen)
    `CHK("const_len", 9'd5, clen)
    `CHK("sweeps", 1'b1, c_hk >= 9 && c_hk <= 11)
    @(posedge clk_in) omask <= 4'hF;
    span(600);
    `CHK("oversweep", 1'b1, ovs)
    rchk("fault_ovs", `PSS_REG_FAULT, 1 << `PSS_FLT_OVSWP, 1 << `PSS_FLT_OVSWP);
    @(posedge clk_in) omask <= 4'h0;
    span(400);
    `CHK("oversweep", 1'b0, ovs)
    svc(`PSS_SVC_CONST, 1'b0, 9'd5);
    span(20);
    `CHK("const_en", 1'b0, cen)
  endtask
  task automatic t_faults();
    @(posedge clk_in) cbad <= 1'b1;
    span(200);
    rchk("fault_cfg", `PSS_REG_FAULT, 1 << `PSS_FLT_CFG, 1 << `PSS_FLT_CFG);
    @(posedge clk_in) cbad <= 1'b0;
    wreg(`PSS_REG_FAULT_CLR, 32'h1F);
    wreg(`PSS_REG_CSUM_CFG, 4);
    @(posedge clk_in) refc <= 16'h0001;
    span(300);
    rchk("fault_csum", `PSS_REG_FAULT, 1 << `PSS_FLT_CSUM, 1 << `PSS_FLT_CSUM);
    rchk("status_csum", `PSS_REG_STATUS, 32'h100, 32'h100);
    load_pgm(16'd10);
    span(300);
    `CHK("solve", 0, c_sol)
    `CHK("pgm_go", 1'b1, c_pg > 0)
    wreg(`PSS_REG_CSUM_CFG, 0);
    wreg(`PSS_REG_FAULT_CLR, 32'h1F);
    wreg(`PSS_REG_CTRL, 1 << `PSS_CTRL_RUN);
    svc(`PSS_SVC_STOP, 1'b0, 9'd0);
    span(300);
    `CHK("io_default", 1'b1, iod)
    rchk("fault_svc", `PSS_REG_FAULT, 1 << `PSS_FLT_SVCSTOP, 1 << `PSS_FLT_SVCSTOP);
    span(200);
    `CHK("solve", 0, c_sol)
  endtask
  task automatic t_wdog();
    wreg(`PSS_REG_FAULT_CLR, 32'h1F);
    wreg(`PSS_REG_CTRL, 1 << `PSS_CTRL_RUN);
    `CHK("health", 1'b1, hok)
    @(posedge clk_in) slow <= 16'd6000;
    span(6500);
    `CHK("health", 1'b0, hok)
    rchk("fault_wdog", `PSS_REG_FAULT, 1 << `PSS_FLT_WDOG, 1 << `PSS_FLT_WDOG);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #150000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_stop();
    t_run();
    t_pgm();
    t_sys();
    t_csw();
    t_faults();
    t_wdog();
    print_verdict();
  end
endmodule
`default_nettype wire
